// [dv/spit_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Behavioural CPU core: power mode, stop instruction, wake on the request
module spit_core_model
    import spit_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       irq_i,
    input  wire logic       granted_i,
    input  wire logic       refused_i,
    output logic      [1:0] power_mode_o,
    output logic            stop_request_o
);
    logic nmi_masked;
    // nmi_masked is set as by software that uses no tick; the wake logic below ignores it
    initial begin
        power_mode_o = SPIT_RUN;
        stop_request_o = 1'b0;
        nmi_masked = 1'b1;
    end
    // The line always wakes the core out of stop
    always @(posedge clk_i) begin
        if (irq_i === 1'b1 && power_mode_o == SPIT_STOP) power_mode_o <= SPIT_RUN;
    end
    task automatic set_mode(input logic [1:0] m);
        @(posedge clk_i);
        power_mode_o <= m;
    endtask
    // Only issued while the tick flag is clear; no tick has set it since reset
    task automatic do_stop(output logic g, output logic r);
        @(posedge clk_i);
        stop_request_o <= 1'b1;
        @(posedge clk_i);
        stop_request_o <= 1'b0;
        #1;
        g = granted_i;
        r = refused_i;
        // Enter the low power mode on an edge, like every other input change
        @(posedge clk_i);
        if (g === 1'b1) power_mode_o <= SPIT_STOP;
    endtask
endmodule
`default_nettype wire

// [dv/spit_timer_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// Port-level checks; the enable bit is shadowed from control writes
module spit_timer_sva
    import spit_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       special_mode_i,
    input wire logic [1:0] power_mode_i,
    input wire logic       stop_request_i,
    input wire logic       nonmaskable_irq_line_o,
    input wire logic       stop_granted_o,
    input wire logic       stop_refused_o
);
    logic en_sh;
    logic next_en_sh;
    logic rd_trim;
    assign rd_trim = reg_rd_i && reg_addr_i == SPIT_TRIM_ADDR;
    // Enable acts on every control write, even with the divide lock closed
    always_comb begin
        next_en_sh = en_sh;
        if (reg_wr_i && reg_addr_i == SPIT_CTRL_ADDR) begin
            next_en_sh = reg_wdata_i[SPIT_TICK_EN_BIT];
        end
    end
    always_ff @(posedge clk_i) begin
        en_sh <= rst_i ? 1'b0 : next_en_sh;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A write one to the tick flag, and a request held in a low power mode
    sequence s_flag_clear;
        reg_wr_i && reg_addr_i == SPIT_CTRL_ADDR && reg_wdata_i[SPIT_TICK_FLAG_BIT];
    endsequence
    sequence s_irq_held;
        nonmaskable_irq_line_o && !$past(reg_wr_i) && power_mode_i inside {SPIT_WAIT, SPIT_STOP};
    endsequence
    chk_trim_low_zero: assert property ($past(rd_trim) |-> reg_rdata_o[3:0] == 4'h0)
        else $error("trim low bits not zero");
    chk_irq_run_en: assert property (nonmaskable_irq_line_o &&
        !($past(power_mode_i) inside {SPIT_WAIT, SPIT_STOP}) |-> $past(en_sh))
        else $error("run mode request without enable");
    chk_irq_held_low: assert property (s_irq_held |=> nonmaskable_irq_line_o)
        else $error("low power request dropped without a clear");
    chk_flag_clear_drop: assert property (s_flag_clear |=> ##1 !nonmaskable_irq_line_o)
        else $error("request survives a flag clear");
    chk_stop_answer: assert property (stop_request_i |=> stop_granted_o ^ stop_refused_o)
        else $error("stop request not answered once");
    chk_stop_quiet: assert property (!$past(stop_request_i) |->
        !stop_granted_o && !stop_refused_o)
        else $error("stop answer without request");
    chk_refuse_pending: assert property (stop_request_i && nonmaskable_irq_line_o &&
        !$past(reg_wr_i) |=> stop_refused_o)
        else $error("stop granted with tick pending");
    chk_grant_no_irq: assert property (stop_granted_o |-> !nonmaskable_irq_line_o)
        else $error("stop granted while request high");
    chk_reset_quiet: assert property ($past(rst_i) |-> !nonmaskable_irq_line_o &&
        reg_rdata_o == 8'h00)
        else $error("outputs active after reset");
    cov_stop: cover property (stop_request_i ##1 stop_granted_o);
endmodule
bind spit_timer spit_timer_sva u_spit_timer_sva (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .special_mode_i, .power_mode_i, .stop_request_i,
    .nonmaskable_irq_line_o, .stop_granted_o, .stop_refused_o);
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
    import spit_pkg::*;
;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       special_mode_i = 1'b0;
    logic [1:0] power_mode_i;
    logic       stop_request_i;
    logic       irq;
    logic       granted;
    logic       refused;
    int         errors = 0;
    int         checks = 0;
    spit_timer u_spit_timer (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .special_mode_i(special_mode_i),
        .power_mode_i(power_mode_i), .stop_request_i(stop_request_i),
        .nonmaskable_irq_line_o(irq), .stop_granted_o(granted), .stop_refused_o(refused));
    spit_core_model u_spit_core_model (.clk_i(clk_i), .irq_i(irq), .granted_i(granted),
        .refused_i(refused), .power_mode_o(power_mode_i), .stop_request_o(stop_request_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle strobes; a gap edge keeps a driver from assigning twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // Count two-cycle reads until a control flag shows, bounded by lim
    task automatic poll(input int b, input int lim, output int n);
        logic [7:0] d;
        n = 0;
        d = 8'h00;
        while (d[b] !== 1'b1 && n < lim) begin
            rd(SPIT_CTRL_ADDR, d);
            n++;
        end
    endtask
    task automatic do_reset(input logic sp);
        rst_i <= 1'b1;
        special_mode_i <= sp;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // Cuts a hang short well past the expected run length
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] d;
        logic       g;
        logic       r;
        int         n1;
        int         n2;
        do_reset(1'b0);
        rc(SPIT_CTRL_ADDR, 8'h00);
        rc(SPIT_TRIM_ADDR, 8'hf0);
        rc(8'h10, 8'h00);
        chk({5'h0, irq, granted, refused}, 8'h00);
        $display("reset values done");
        wr(SPIT_CTRL_ADDR, 8'h08);
        rc(SPIT_CTRL_ADDR, 8'h08);
        poll(SPIT_LOWER_FLAG_BIT, 64, n1);
        chk({7'h0, n1 > 8 && n1 < 24}, 8'h01);
        poll(SPIT_UPPER_FLAG_BIT, 5000, n1);
        chk({7'h0, n1 > 3800 && n1 < 4300}, 8'h01);
        $display("overflow flags done");
        wr(SPIT_CTRL_ADDR, 8'h4c);
        rc(SPIT_CTRL_ADDR, 8'h4b);
        chk({7'h0, irq}, 8'h00);
        wr(SPIT_CTRL_ADDR, 8'h43);
        rd(SPIT_CTRL_ADDR, d);
        chk(d & 8'hfe, 8'h48);
        wr(SPIT_TRIM_ADDR, 8'h30);
        wr(SPIT_TRIM_ADDR, 8'h50);
        rc(SPIT_TRIM_ADDR, 8'h30);
        wr(SPIT_TEST_ADDR, 8'h04);
        rc(SPIT_TEST_ADDR, 8'h00);
        $display("normal mode locks done");
        for (int m = 0; m < 4; m++) begin
            u_spit_core_model.set_mode(m[1:0]);
            u_spit_core_model.do_stop(g, r);
            chk({6'h0, g, r}, 8'h02);
        end
        u_spit_core_model.set_mode(SPIT_RUN);
        $display("stop requests done");
        do_reset(1'b1);
        rc(SPIT_TRIM_ADDR, 8'hf0);
        wr(SPIT_CTRL_ADDR, 8'h0c);
        rc(SPIT_CTRL_ADDR, 8'h0c);
        wr(SPIT_CTRL_ADDR, 8'h04);
        rc(SPIT_CTRL_ADDR, 8'h04);
        wr(SPIT_TEST_ADDR, 8'h04);
        rc(SPIT_TEST_ADDR, 8'h04);
        wr(SPIT_TEST_ADDR, 8'h00);
        wr(SPIT_CTRL_ADDR, 8'h8b);
        poll(SPIT_LOWER_FLAG_BIT, 64, n1);
        wr(SPIT_CTRL_ADDR, 8'h8b);
        wr(SPIT_TRIM_ADDR, 8'h80);
        poll(SPIT_LOWER_FLAG_BIT, 64, n2);
        // Trim 8 leaves 9 steps to the nibble wrap instead of 16; a missed
        // preset would land within a read or two of n1
        chk({7'h0, n2 > 2 && n2 < n1 - 4}, 8'h01);
        wr(SPIT_TRIM_ADDR, 8'h90);
        rc(SPIT_TRIM_ADDR, 8'h90);
        wr(SPIT_TEST_ADDR, 8'h04);
        special_mode_i <= 1'b0;
        rc(SPIT_TEST_ADDR, 8'h00);
        $display("special mode done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [logic/spit_chain.sv]
`timescale 1ns/1ns
`default_nettype none
// 23-bit down counter chain: 4-bit prescaler, then 4-, 8- and 7-bit parts
module spit_chain
    import spit_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] divide_select_i,
    input  wire logic [3:0] trim_value_i,
    input  wire logic       preset_i,
    input  wire logic       bypass_i,
    output logic            tick_o,
    output logic            lower_ovf_o,
    output logic            upper_ovf_o
);

    logic [3:0]  presc;
    logic [18:0] count;
    logic [3:0]  next_presc;
    logic [18:0] next_count;
    logic        next_tick;
    logic        next_lower;
    logic        next_upper;
    logic        step;

    // Prescaler gates one step of the three counter parts per 2..16 clocks
    always_comb begin
        step       = ((presc & spit_presc_mask(divide_select_i)) == 4'h0);
        next_presc = presc - 4'h1;
        next_count = count;
        next_tick  = 1'b0;
        next_lower = 1'b0;
        next_upper = 1'b0;
        if (preset_i) begin
            // Restart a full prescaler period so the first tick is not short
            next_presc = SPIT_PRESC_RESET;                        // [RULE4] [RULE18]
            next_count = spit_reload(trim_value_i);               // [RULE4] [RULE18]
        end else if (step) begin
            next_lower = (count[3:0] == 4'h0);                    // [RULE8] [RULE16]
            next_upper = (count[11:0] == 12'h000);                // [RULE8] [RULE16]
            if (count == 19'h00000) begin
                next_tick  = 1'b1;                                // [RULE5]
                // Bypass lets the chain wrap so every bit toggles in test
                next_count = bypass_i ? SPIT_COUNT_ALL_ONES
                                      : spit_reload(trim_value_i); // [RULE6] [RULE7] [RULE19]
            end else begin
                next_count = count - 19'h00001;
            end
        end
    end

    // Chain state and one-cycle event pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc       <= SPIT_PRESC_RESET;
            count       <= SPIT_COUNT_RESET;
            tick_o      <= 1'b0;
            lower_ovf_o <= 1'b0;
            upper_ovf_o <= 1'b0;
        end else begin
            presc       <= next_presc;
            count       <= next_count;
            tick_o      <= next_tick;
            lower_ovf_o <= next_lower;
            upper_ovf_o <= next_upper;
        end
    end

endmodule
`default_nettype wire

// [logic/spit_pkg.sv]
`default_nettype none
package spit_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0]  SPIT_TRIM_ADDR       = 8'h33;
    localparam logic [7:0]  SPIT_CTRL_ADDR       = 8'h34;
    localparam logic [7:0]  SPIT_TEST_ADDR       = 8'h3e;

    // Control register fields
    localparam int          SPIT_TICK_FLAG_BIT   = 7;
    localparam int          SPIT_TICK_EN_BIT     = 6;
    localparam int          SPIT_DIV_HI_BIT      = 3;
    localparam int          SPIT_DIV_LO_BIT      = 2;
    localparam int          SPIT_UPPER_FLAG_BIT  = 1;
    localparam int          SPIT_LOWER_FLAG_BIT  = 0;

    // Trim register field and test register field
    localparam int          SPIT_TRIM_HI_BIT     = 7;
    localparam int          SPIT_TRIM_LO_BIT     = 4;
    localparam int          SPIT_BYPASS_BIT      = 2;

    // Reset values
    localparam logic [1:0]  SPIT_DIV_RESET       = 2'h0;
    localparam logic [3:0]  SPIT_TRIM_RESET      = 4'hf;

    // Divide select codes and the prescaler masks they choose
    localparam logic [1:0]  SPIT_DIV_HALF        = 2'h0;
    localparam logic [1:0]  SPIT_DIV_QUARTER     = 2'h1;
    localparam logic [1:0]  SPIT_DIV_EIGHTH      = 2'h2;
    localparam logic [1:0]  SPIT_DIV_ONE         = 2'h3;
    localparam logic [3:0]  SPIT_MASK_BY16       = 4'hf;
    localparam logic [3:0]  SPIT_MASK_BY8        = 4'h7;
    localparam logic [3:0]  SPIT_MASK_BY4        = 4'h3;
    localparam logic [3:0]  SPIT_MASK_BY2        = 4'h1;

    // Upper and middle counter preset for positive and negative trim
    localparam logic [14:0] SPIT_PRESET_POS      = 15'h4000;
    localparam logic [14:0] SPIT_PRESET_NEG      = 15'h3fff;
    localparam logic [18:0] SPIT_COUNT_ALL_ONES  = 19'h7ffff;

    // CPU power mode as seen from the core
    typedef enum logic [1:0] {
        SPIT_RUN  = 2'b00,
        SPIT_WAIT = 2'b01,
        SPIT_STOP = 2'b10
    } spit_power_t;

    // Prescaler mask: low bits that must all be zero for one counter step
    function automatic logic [3:0] spit_presc_mask(input logic [1:0] div);
        logic [3:0] m;
        m = SPIT_MASK_BY8;
        case (div)
            SPIT_DIV_HALF:    m = SPIT_MASK_BY8;
            SPIT_DIV_QUARTER: m = SPIT_MASK_BY4;
            SPIT_DIV_EIGHTH:  m = SPIT_MASK_BY2;
            default:          m = SPIT_MASK_BY16;
        endcase
        return m;
    endfunction

    // Reload value of the 19-bit counter part; trim 8..15 counts as negative
    function automatic logic [18:0] spit_reload(input logic [3:0] trim);
        return trim[3] ? {SPIT_PRESET_NEG, trim} : {SPIT_PRESET_POS, trim};
    endfunction

    localparam logic [18:0] SPIT_COUNT_RESET     = {SPIT_PRESET_NEG, SPIT_TRIM_RESET};
    localparam logic [3:0]  SPIT_PRESC_RESET     = 4'hf;

endpackage
`default_nettype wire

// [logic/spit_timer.sv]
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE1] The chain counts on the crystal clock itself, no other divider.
// [RULE2] Divide select 00/01/10/11 gives 2097152/1048576/524288/4194304 clocks per tick.
// [RULE3] In normal modes only the first divide select write after reset counts.
// [RULE4] Writing divide select restarts the chain from the new reload value.
// [RULE5] Counter reaching zero sets the slow tick flag.
// [RULE6] Zero reload: low four bits get trim, upper parts $4000 or $3FFF.
// [RULE7] Trim moves the ratio from 27 ppm below to 31 ppm above nominal.
// [RULE8] Lower flag on overflow past bit 4, upper flag at bit 12.
// [RULE9] The three flags clear only by writing a one to their bit.
// [RULE10] The tick request drives the nonmaskable interrupt line.
// [RULE11] In run mode the request needs the tick enable bit.
// [RULE12] In wait and stop modes the request ignores the enable bit.
// [RULE13] A set tick flag refuses a stop instruction.
// [RULE14] Software should clear the tick flag before executing stop.
// [RULE15] Software unmasks the nonmaskable interrupt only when it uses the tick.
// [RULE16] Chain is 23 bits: prescaler 4, counters 4, 8 and 7, each overflowing.
// [RULE17] Special modes lift the write-once limit on trim and divide select.
// [RULE18] Special modes: each trim write presets the chain at once.
// [RULE19] Special mode with bypass: no reload after a tick.
// [RULE20] Trim sits in bits 7..4, low bits read zero, resets to 1111.
// [RULE21] Request is a level: flag and (enable or wait or stop).
module spit_timer
    import spit_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       special_mode_i,
    input  wire logic [1:0] power_mode_i,
    input  wire logic       stop_request_i,
    output logic            nonmaskable_irq_line_o,
    output logic            stop_granted_o,
    output logic            stop_refused_o
);

    // Software-visible state, plus the hidden write-once locks
    logic       slow_tick_flag;
    logic       slow_tick_enable;
    logic       upper_chain_overflow_flag;
    logic       lower_chain_overflow_flag;
    logic [1:0] divide_select;
    logic [3:0] trim_value;
    logic       counter_bypass_test;
    logic       divide_locked;
    logic       trim_locked;

    logic       next_slow_tick_flag;
    logic       next_slow_tick_enable;
    logic       next_upper_flag;
    logic       next_lower_flag;
    logic [1:0] next_divide_select;
    logic [3:0] next_trim_value;
    logic       next_bypass;
    logic       next_divide_locked;
    logic       next_trim_locked;

    // Bus decode
    logic       ctrl_wr;
    logic       trim_wr;
    logic       test_wr;
    logic       divide_accept;
    logic       trim_accept;
    logic       chain_preset;

    // Chain events
    logic       chain_tick;
    logic       chain_lower_ovf;
    logic       chain_upper_ovf;

    // Outputs
    logic [7:0] next_rdata;
    logic       next_irq;
    logic       next_stop_granted;
    logic       next_stop_refused;
    logic       low_power;

    spit_power_t power_mode;

    // Address decode of the write strobe
    always_comb begin
        ctrl_wr = reg_wr_i && (reg_addr_i == SPIT_CTRL_ADDR);
        trim_wr = reg_wr_i && (reg_addr_i == SPIT_TRIM_ADDR);
        test_wr = reg_wr_i && (reg_addr_i == SPIT_TEST_ADDR) && special_mode_i;
    end

    // Write-once gates; special modes may rewrite at any time
    always_comb begin
        divide_accept = ctrl_wr && (special_mode_i || !divide_locked);  // [RULE3] [RULE17]
        trim_accept   = trim_wr && (special_mode_i || !trim_locked);    // [RULE17]
        // Divide change always restarts; trim restarts only in special mode
        chain_preset  = divide_accept || (trim_accept && special_mode_i); // [RULE4] [RULE18]
    end

    // Configuration registers: enable, divide select, trim, bypass, locks
    always_comb begin
        next_slow_tick_enable = slow_tick_enable;
        next_divide_select    = divide_select;
        next_trim_value       = trim_value;
        next_bypass           = counter_bypass_test;
        next_divide_locked    = divide_locked;
        next_trim_locked      = trim_locked;
        if (ctrl_wr) begin
            next_slow_tick_enable = reg_wdata_i[SPIT_TICK_EN_BIT];
        end
        if (divide_accept) begin
            next_divide_select = reg_wdata_i[SPIT_DIV_HI_BIT:SPIT_DIV_LO_BIT]; // [RULE2] [RULE3]
            next_divide_locked = 1'b1;                                      // [RULE3]
        end
        if (trim_accept) begin
            next_trim_value  = reg_wdata_i[SPIT_TRIM_HI_BIT:SPIT_TRIM_LO_BIT]; // [RULE20]
            next_trim_locked = 1'b1;
        end
        // Bypass only exists in special mode; leaving special mode drops it
        if (!special_mode_i) begin
            next_bypass = 1'b0;
        end else if (test_wr) begin
            next_bypass = reg_wdata_i[SPIT_BYPASS_BIT];                     // [RULE19]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_tick_enable    <= 1'b0;
            divide_select       <= SPIT_DIV_RESET;
            trim_value          <= SPIT_TRIM_RESET;                         // [RULE20]
            counter_bypass_test <= 1'b0;
            divide_locked       <= 1'b0;
            trim_locked         <= 1'b0;
        end else begin
            slow_tick_enable    <= next_slow_tick_enable;
            divide_select       <= next_divide_select;
            trim_value          <= next_trim_value;
            counter_bypass_test <= next_bypass;
            divide_locked       <= next_divide_locked;
            trim_locked         <= next_trim_locked;
        end
    end

    // Counter chain runs straight on the crystal clock; it sees the value
    // being written so a preset already uses the new select and trim
    spit_chain u_chain (
        .clk_i           (clk_i),                                           // [RULE1]
        .rst_i           (rst_i),
        .divide_select_i (next_divide_select),
        .trim_value_i    (next_trim_value),
        .preset_i        (chain_preset),
        .bypass_i        (counter_bypass_test && special_mode_i),           // [RULE19]
        .tick_o          (chain_tick),
        .lower_ovf_o     (chain_lower_ovf),
        .upper_ovf_o     (chain_upper_ovf)
    );

    // Sticky flags: write one to clear, zero leaves them; a set in the
    // same cycle as the clear wins so no event is lost
    always_comb begin
        next_slow_tick_flag = chain_tick ||                                 // [RULE5]
            (slow_tick_flag && !(ctrl_wr && reg_wdata_i[SPIT_TICK_FLAG_BIT])); // [RULE9]
        next_upper_flag = chain_upper_ovf ||                                // [RULE8]
            (upper_chain_overflow_flag &&
             !(ctrl_wr && reg_wdata_i[SPIT_UPPER_FLAG_BIT]));               // [RULE9]
        next_lower_flag = chain_lower_ovf ||                                // [RULE8]
            (lower_chain_overflow_flag &&
             !(ctrl_wr && reg_wdata_i[SPIT_LOWER_FLAG_BIT]));               // [RULE9]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_tick_flag            <= 1'b0;
            upper_chain_overflow_flag <= 1'b0;
            lower_chain_overflow_flag <= 1'b0;
        end else begin
            slow_tick_flag            <= next_slow_tick_flag;
            upper_chain_overflow_flag <= next_upper_flag;
            lower_chain_overflow_flag <= next_lower_flag;
        end
    end

    // Power mode decode; the unused code behaves as run so it never
    // bypasses the enable by accident
    always_comb begin
        power_mode = spit_power_t'(power_mode_i);
        low_power  = 1'b0;
        unique case (power_mode)
            SPIT_RUN:  low_power = 1'b0;                                    // [RULE11]
            SPIT_WAIT: low_power = 1'b1;                                    // [RULE12]
            SPIT_STOP: low_power = 1'b1;                                    // [RULE12]
            default:   low_power = 1'b0;
        endcase
    end

    // Interrupt request level; it follows the flag one cycle later, and the
    // enable bit only masks it while the core is running
    always_comb begin
        next_irq = slow_tick_flag && (slow_tick_enable || low_power);       // [RULE11] [RULE12] [RULE21]
    end

    // Stop handshake: the core offers a stop for one cycle and learns at the
    // next edge whether it may sleep; software is expected to have cleared
    // the flag first, otherwise the request is turned down
    always_comb begin
        next_stop_granted = stop_request_i && !slow_tick_flag;              // [RULE13] [RULE14]
        next_stop_refused = stop_request_i &&  slow_tick_flag;              // [RULE13]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nonmaskable_irq_line_o <= 1'b0;
            stop_granted_o         <= 1'b0;
            stop_refused_o         <= 1'b0;
        end else begin
            nonmaskable_irq_line_o <= next_irq;                             // [RULE10]
            stop_granted_o         <= next_stop_granted;
            stop_refused_o         <= next_stop_refused;
        end
    end

    // Read mux; reserved bits and unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                SPIT_CTRL_ADDR: begin
                    next_rdata[SPIT_TICK_FLAG_BIT]  = slow_tick_flag;
                    next_rdata[SPIT_TICK_EN_BIT]    = slow_tick_enable;
                    next_rdata[SPIT_DIV_HI_BIT:SPIT_DIV_LO_BIT] = divide_select;
                    next_rdata[SPIT_UPPER_FLAG_BIT] = upper_chain_overflow_flag;
                    next_rdata[SPIT_LOWER_FLAG_BIT] = lower_chain_overflow_flag;
                end
                SPIT_TRIM_ADDR: begin
                    next_rdata[SPIT_TRIM_HI_BIT:SPIT_TRIM_LO_BIT] = trim_value; // [RULE20]
                end
                SPIT_TEST_ADDR: begin
                    next_rdata[SPIT_BYPASS_BIT] = counter_bypass_test;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule
`default_nettype wire
